// >>> verilog/serial_adc_mode_control.sv
// Mode control and serial readout of an 8-bit sampling converter
`include "conv_params.svh"
`default_nettype none
module serial_adc_mode_control
  import conv_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [`RESULT_BITS-1:0] sample_code_i,
  output logic serial_result_out_o,
  output logic serial_result_oe_o,
  output logic track_o,
  output logic powered_o,
  output logic result_valid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic cs_n_lvl;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  pin_sync #(.RESET_VAL(1'b1)) u_cs_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(cs_n_i),
    .level_o(cs_n_lvl),
    .rise_o(cs_rise),
    .fall_o(cs_fall)
  );

  // Reset to the idle-high level so release gives no false edge
  pin_sync #(.RESET_VAL(1'b1)) u_sclk_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(sclk_i),
    .level_o(),
    .rise_o(sclk_rise),
    .fall_o(sclk_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame state
  pwr_mode_t mode_r;
  pwr_mode_t mode_nxt;
  logic [4:0] fall_cnt_r;
  logic [4:0] rise_cnt_r;
  logic active_r;
  logic oe_r;
  logic oe_nxt;
  logic dout_r;
  logic track_r;
  logic [`RESULT_BITS-1:0] held_r;
  logic dummy_r;
  logic valid_r;

  wire in_frame = active_r & ~cs_n_lvl;
  wire cnt_sat = (fall_cnt_r == 5'(`FRAME_BITS));
  wire frame_done = in_frame & sclk_fall & (fall_cnt_r == 5'(`FRAME_BITS - 1));
  wire [4:0] next_fall = fall_cnt_r + 5'h01;
  // Fall n shifts out bit n-1: three zeros, eight code bits, then zeros
  wire [4:0] bit_idx = fall_cnt_r;
  wire data_span = (bit_idx >= 5'(`LEAD_ZEROS)) && (bit_idx < 5'(`LEAD_ZEROS + `RESULT_BITS));
  wire [2:0] msb_off = 3'(bit_idx - 5'(`LEAD_ZEROS));
  wire next_bit = data_span ? held_r[3'(`RESULT_BITS-1) - msb_off] : 1'b0;
  // Select level is already high when its rise is seen, so qualify by the frame flag
  wire early_rise = active_r & cs_rise & (fall_cnt_r < 5'(`GLITCH_FALL_EDGE));
  wire mid_rise = active_r & cs_rise & (fall_cnt_r >= 5'(`GLITCH_FALL_EDGE))
                  & (fall_cnt_r < 5'(`SHUTDOWN_FALL_EDGE));
  wire wake_rise = active_r & cs_rise & (mode_r == MODE_WAKING)
                   & (fall_cnt_r < 5'(`SHUTDOWN_FALL_EDGE));
  wire late_rise = active_r & cs_rise & (fall_cnt_r >= 5'(`SHUTDOWN_FALL_EDGE)) & ~cnt_sat;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decisions
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_NORMAL: begin
        if (mid_rise) begin
          mode_nxt = MODE_SHUTDOWN;
        end
      end
      MODE_SHUTDOWN: begin
        if (cs_fall) begin
          mode_nxt = MODE_WAKING;
        end
      end
      MODE_WAKING: begin
        if (wake_rise) begin
          mode_nxt = MODE_SHUTDOWN;
        end else if (frame_done) begin
          mode_nxt = MODE_NORMAL;
        end
      end
      default: mode_nxt = MODE_SHUTDOWN;
    endcase
  end

  // Any select rise or the last fall releases the output
  always_comb begin
    oe_nxt = oe_r;
    if (cs_fall) begin
      oe_nxt = 1'b1;
    end else if (cs_rise | frame_done) begin
      oe_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_r <= MODE_SHUTDOWN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fall_cnt_r <= `EDGE_CNT_RESET;
      rise_cnt_r <= `EDGE_CNT_RESET;
      active_r <= 1'b0;
    end else if (cs_fall) begin
      fall_cnt_r <= `EDGE_CNT_RESET;
      rise_cnt_r <= `EDGE_CNT_RESET;
      active_r <= 1'b1;
    end else if (cs_rise) begin
      active_r <= 1'b0;
    end else if (in_frame) begin
      if (sclk_fall && !cnt_sat) begin
        fall_cnt_r <= next_fall;
      end
      if (sclk_rise && rise_cnt_r != 5'h1f) begin
        rise_cnt_r <= rise_cnt_r + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      oe_r <= 1'b0;
      dout_r <= 1'b0;
      held_r <= 8'h00;
    end else begin
      oe_r <= oe_nxt;
      if (cs_fall) begin
        held_r <= sample_code_i;
        dout_r <= 1'b0;
      end else if (in_frame && sclk_fall && !cnt_sat) begin
        dout_r <= next_bit;
      end
    end
  end

  // Hold from select fall until the 13th rise
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      track_r <= 1'b1;
    end else if (cs_fall) begin
      track_r <= 1'b0;
    end else if (in_frame && sclk_rise && rise_cnt_r == 5'(`TRACK_RISE_EDGE - 1)) begin
      track_r <= 1'b1;
    end else if (!active_r) begin
      track_r <= 1'b1;
    end
  end

  // A wake frame spans the power-up time, so its result is a dummy
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dummy_r <= 1'b1;
      valid_r <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      if (cs_fall) begin
        dummy_r <= (mode_r != MODE_NORMAL);
      end
      if (frame_done) begin
        valid_r <= ~dummy_r;
      end
    end
  end

  assign serial_result_out_o = dout_r;
  assign serial_result_oe_o = oe_r;
  assign track_o = track_r;
  assign powered_o = (mode_r == MODE_NORMAL);
  assign result_valid_o = valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  shutdown_entry_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (mid_rise && mode_r == MODE_NORMAL) |=> (mode_r == MODE_SHUTDOWN && !serial_result_oe_o))
    else $error("Mid-frame select rise did not shut down");
  glitch_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (early_rise && mode_r == MODE_NORMAL) |=> mode_r == MODE_NORMAL)
    else $error("Early select rise changed mode");
  late_abort_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (late_rise && mode_r == MODE_NORMAL) |=> (mode_r == MODE_NORMAL && !serial_result_oe_o))
    else $error("Late select rise not handled");
  shutdown_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (mode_r == MODE_SHUTDOWN && !cs_fall) |=> mode_r == MODE_SHUTDOWN)
    else $error("Left shutdown without select fall");
  select_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cs_fall |=> (serial_result_oe_o && held_r == $past(sample_code_i) && !track_o))
    else $error("Select fall did not sample and drive");
  frame_end_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    frame_done |=> !serial_result_oe_o)
    else $error("Output not released after sixteen clocks");
  track_return_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (in_frame && sclk_rise && rise_cnt_r == 5'd12) |=> track_o)
    else $error("No track at rise edge 13");
  wake_fallback_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wake_rise |=> mode_r == MODE_SHUTDOWN)
    else $error("Waking rise did not return to shutdown");
  wake_done_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (mode_r == MODE_WAKING && frame_done) |=> powered_o ##0 !result_valid_o)
    else $error("Wake frame not completed properly");
  data_msb_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (in_frame && sclk_fall && fall_cnt_r == 5'd3) |=> serial_result_out_o == held_r[7])
    else $error("MSB not on fourth fall");
  lead_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (in_frame && sclk_fall && fall_cnt_r < 5'd3) |=> !serial_result_out_o)
    else $error("Leading zero missing");
endmodule // serial_adc_mode_control
`default_nettype wire

// >>> verilog/conv_params.svh
// Constants for the serial converter control block
`ifndef CONV_PARAMS_SVH
`define CONV_PARAMS_SVH
`define RESULT_BITS 8
`define CODE_LEVELS 256
`define LEAD_ZEROS 3
`define FRAME_BITS 16
`define TRACK_RISE_EDGE 13
`define GLITCH_FALL_EDGE 2
`define SHUTDOWN_FALL_EDGE 10
`define CLK_PERIOD_NS 50
`define POWER_UP_NS 1000
`define POWER_UP_CYCLES ((`POWER_UP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QUIET_INTERVAL_NS 50
`define ACQUISITION_INTERVAL_NS 350
`define EDGE_CNT_RESET 5'h00
`endif

// >>> verilog/conv_pkg.sv
// Types shared by the converter control block
`default_nettype none
package conv_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_SHUTDOWN, MODE_WAKING} pwr_mode_t;
endpackage
`default_nettype wire

// >>> verilog/pin_sync.sv
// Two-flop synchroniser with edge detection on the synchronised level
`default_nettype none
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
      prev_r <= RESET_VAL;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o = sync_r & ~prev_r;
  assign fall_o = ~sync_r & prev_r;
endmodule // pin_sync
`default_nettype wire

// >>> verification/host_model.sv
// Host controller model that frames one readout of the converter
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [4:0] n_falls_i,
  input wire logic result_line_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [15:0] word_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    word_o = 16'h0000;
    busy_o = 1'b0;
  end
  // Sclk stands high between frames; one period is 8 clk, 400 ns
  always begin
    @(posedge clk_i);
    if (start_i) begin
      busy_o <= 1'b1;
      cs_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (int k = 0; k < n_falls_i; k++) begin
        sclk_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        sclk_o <= 1'b1;
        // Value seen just before the rise lands
        word_o <= {word_o[14:0], result_line_i};
        repeat (4) @(posedge clk_i);
      end
      cs_n_o <= 1'b1;
      // Long enough for both quiet and acquisition spans
      repeat (16) @(posedge clk_i);
      busy_o <= 1'b0;
    end
  end
endmodule // host_model
`default_nettype wire

// >>> verification/serial_adc_mode_control_tb_top.sv
// Self-checking bench for the converter mode control block
`include "conv_params.svh"
`default_nettype none
module serial_adc_mode_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [`RESULT_BITS-1:0] code = 8'h00;
  logic start = 1'b0;
  logic [4:0] n_falls = 5'h00;
  logic cs_n, sclk, dout, oe, track, powered, valid, busy;
  logic last_r = 1'b0;
  logic valid_seen = 1'b0;
  logic hold_seen = 1'b0;
  logic clr_seen = 1'b0;
  logic [15:0] word;
  int n_mismatch = 0;
  int n_tests = 0;
  // Released line shows the inverse, so a stale bit never matches
  wire logic result_line = oe ? dout : ~last_r;
  serial_adc_mode_control i_serial_adc_mode_control (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n),
    .sclk_i(sclk), .sample_code_i(code), .serial_result_out_o(dout), .serial_result_oe_o(oe),
    .track_o(track), .powered_o(powered), .result_valid_o(valid));
  host_model i_host_model (.clk_i(clk_i), .start_i(start), .n_falls_i(n_falls), .result_line_i(result_line),
    .cs_n_o(cs_n), .sclk_o(sclk), .word_o(word), .busy_o(busy));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (oe === 1'b1) last_r <= dout;
    if (clr_seen) begin
      valid_seen <= 1'b0;
      hold_seen <= 1'b0;
    end else begin
      if (valid === 1'b1) valid_seen <= 1'b1;
      if (track === 1'b0) hold_seen <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [4:0] n, input logic [7:0] c);
    @(posedge clk_i);
    start <= 1'b1;
    n_falls <= n;
    code <= c;
    clr_seen <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    clr_seen <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk_i);
    if (busy !== 1'b0) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, busy, 1'b0);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_dummy();
    chk(16'(powered), 16'h0000);
    frame(5'd16, 8'h3c);
    chk(16'(valid_seen), 16'h0000);
    chk(16'(powered), 16'h0001);
    $display("test dummy done");
  endtask
  task automatic t_full();
    logic [7:0] codes [3] = '{8'ha5, 8'hff, 8'h01};
    foreach (codes[i]) begin
      frame(5'd16, codes[i]);
      // Rise 16 samples the released line, which the bench shows inverted
      chk(word, {3'b000, codes[i], 4'h0, 1'b1});
      chk({14'h0, valid_seen, hold_seen}, 16'h0003);
      chk({14'h0, track, oe}, 16'h0002);
    end
    $display("test full done");
  endtask
  task automatic t_cut();
    frame(5'd1, 8'h11);
    chk({14'h0, powered, oe}, 16'h0002);
    frame(5'd10, 8'h22);
    chk({13'h0, valid_seen, powered, oe}, 16'h0002);
    frame(5'd16, 8'h33);
    chk(word, {3'b000, 8'h33, 4'h0, 1'b1});
    chk(16'(valid_seen), 16'h0001);
    $display("test cut done");
  endtask
  task automatic t_shut();
    frame(5'd2, 8'h44);
    chk({14'h0, powered, oe}, 16'h0000);
    repeat (40) @(posedge clk_i);
    chk(16'(powered), 16'h0000);
    frame(5'd9, 8'h55);
    chk(16'(powered), 16'h0000);
    frame(5'd16, 8'h66);
    chk({14'h0, valid_seen, powered}, 16'h0001);
    frame(5'd16, 8'h5a);
    chk(word, {3'b000, 8'h5a, 4'h0, 1'b1});
    chk(16'(valid_seen), 16'h0001);
    $display("test shut done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_dummy();
    t_full();
    t_cut();
    t_shut();
    report_and_stop();
  end
  // About fifteen times the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule // serial_adc_mode_control_tb_top
`default_nettype wire
